// file: design/iopc_pin_ctrl.sv
`timescale 1ns/1ps
module iopc_pin_ctrl #(
  parameter int DEBOUNCE_CYCLES = iopc_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  // Pin configuration
  input  wire logic [iopc_pkg::NUM_PINS-1:0][1:0] i_out_mode,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_pull_up_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_pull_down_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0][2:0] i_drive_strength,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_filter_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_analog_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0][2:0] i_pin_function_selector,
  // Interrupt configuration
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_int_edge_mode,
  input  wire logic [iopc_pkg::NUM_PINS-1:0][1:0] i_int_trigger,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_int_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_int_clear,
  // Function sources
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_gpio_out,
  input  wire logic [iopc_pkg::NUM_PINS-1:0][7:0] i_func_out,
  input  wire logic [iopc_pkg::NUM_PINS-1:0][7:0] i_func_oe,
  input  wire logic [7:0]                        i_timer_b_pwm_output,
  input  wire logic [7:0]                        i_timer_c_pwm_output,
  input  wire logic                              i_debug_swdio_out,
  input  wire logic                              i_debug_swdio_oe,
  input  wire logic                              i_debug_tdo_out,
  // Pads
  input  wire logic [iopc_pkg::NUM_PINS-1:0]      i_pad_in,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_pad_out,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_pad_oe,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_pull_up,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_pull_down,
  output logic      [iopc_pkg::NUM_PINS-1:0][2:0] o_drive_strength,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_analog_route,
  output logic      [iopc_pkg::NUM_ADC-1:0]       o_adc_channel_en,
  // Status
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_pin_in,
  output logic      [iopc_pkg::NUM_PINS-1:0]      o_int_flag,
  output logic                                   o_irq
);

  localparam int NP = iopc_pkg::NUM_PINS;
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(DEBOUNCE_CYCLES - 1);

  if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
    $error("DEBOUNCE_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [NP-1:0]         sync1;
    logic [NP-1:0]         sync2;
    logic [NP-1:0]         filt;
    logic [NP-1:0]         prev;
    logic [NP-1:0]         flag;
    logic [NP-1:0]         pad_out;
    logic [NP-1:0]         pad_oe;
    logic [NP-1:0]         pull_up;
    logic [NP-1:0]         pull_dn;
    logic [NP-1:0]         analog;
    logic [NP-1:0][2:0]    drive;
    logic [NP-1:0][CW-1:0] cnt;
    logic [7:0]            adc;
    logic                  irq;
  } iopc_state_t;

  iopc_state_t q;
  iopc_state_t d;
  logic [NP-1:0] event_w;

  //////////////////////////////////////////////////////////////////////////

  // Returns {oe, out} of the function selected on pin p
  function automatic logic [1:0] pin_source(input int p,
                                            input logic [2:0] sel);
    logic [1:0] r;
    r = {i_func_oe[p][sel], i_func_out[p][sel]};
    if (sel == iopc_pkg::SEL_GPIO) begin
      r = {1'b1, i_gpio_out[p]};
    end else if (p <= iopc_pkg::PORT_D_LAST &&
                 sel == iopc_pkg::SEL_TIMER_B) begin
      r = {1'b1, i_timer_b_pwm_output[3'(p % 8)]};
    end else if (p <= iopc_pkg::PORT_D_LAST &&
                 sel == iopc_pkg::SEL_TIMER_C) begin
      r = {1'b1, i_timer_c_pwm_output[3'(p % 8)]};
    end else if (sel == iopc_pkg::SEL_DEBUG) begin
      if (p == iopc_pkg::DBG_CLK_PIN || p == iopc_pkg::DBG_TDI_PIN) begin
        r = 2'h0;
      end else if (p == iopc_pkg::DBG_TMS_PIN) begin
        r = {i_debug_swdio_oe, i_debug_swdio_out};
      end else if (p == iopc_pkg::DBG_TDO_PIN) begin
        r = {1'b1, i_debug_tdo_out};
      end
    end
    return r;
  endfunction : pin_source

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [1:0] src;
    logic       rise;
    logic       fall;
    logic [2:0] ch;
    src  = 2'h0;
    rise = 1'b0;
    fall = 1'b0;
    ch   = 3'h0;
    d    = q;
    d.sync1 = i_pad_in;
    d.sync2 = q.sync1;
    d.prev  = q.filt;
    d.adc   = '0;
    for (int p = 0; p < NP; p++) begin
      // Debounce: accept a new level after it held for the full count
      if (!i_filter_en[p] || q.sync2[p] == q.filt[p]) begin
        d.cnt[p]  = '0;
        d.filt[p] = q.sync2[p];
      end else if (q.cnt[p] == CNT_LAST) begin
        d.cnt[p]  = '0;
        d.filt[p] = q.sync2[p];
      end else begin
        d.cnt[p] = q.cnt[p] + CW'(1);
      end
      rise = q.filt[p] & ~q.prev[p];
      fall = ~q.filt[p] & q.prev[p];
      if (i_int_edge_mode[p]) begin
        event_w[p] = (rise & i_int_trigger[p][iopc_pkg::TRIG_RISE_BIT]) |
                     (fall & i_int_trigger[p][iopc_pkg::TRIG_FALL_BIT]);
      end else begin
        event_w[p] =
          (q.filt[p] & i_int_trigger[p][iopc_pkg::TRIG_RISE_BIT]) |
          (~q.filt[p] & i_int_trigger[p][iopc_pkg::TRIG_FALL_BIT]);
      end
      d.flag[p] = event_w[p] | (q.flag[p] & ~i_int_clear[p]);
      // Output stage
      src = pin_source(p, i_pin_function_selector[p]);
      ch  = iopc_pkg::adc_channel(p);
      d.analog[p] = i_analog_en[p] && ch != 3'h0;
      d.drive[p]  = i_drive_strength[p];
      if (d.analog[p]) begin
        d.pad_oe[p]  = 1'b0;
        d.pad_out[p] = 1'b0;
        d.pull_up[p] = 1'b0;
        d.pull_dn[p] = 1'b0;
        d.adc[ch]    = 1'b1;
      end else begin
        d.pull_up[p] = i_pull_up_en[p];
        d.pull_dn[p] = i_pull_down_en[p];
        if (i_out_mode[p] == iopc_pkg::MODE_PUSH_PULL) begin
          d.pad_oe[p]  = src[1];
          d.pad_out[p] = src[0];
        end else if (i_out_mode[p] == iopc_pkg::MODE_OPEN_DRAIN) begin
          d.pad_oe[p]  = src[1] & ~src[0];
          d.pad_out[p] = 1'b0;
        end else begin
          d.pad_oe[p]  = 1'b0;
          d.pad_out[p] = 1'b0;
        end
      end
    end
    d.irq = |(q.flag & i_int_en);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_pad_out        = q.pad_out;
  assign o_pad_oe         = q.pad_oe;
  assign o_pull_up        = q.pull_up;
  assign o_pull_down      = q.pull_dn;
  assign o_drive_strength = q.drive;
  assign o_analog_route   = q.analog;
  assign o_adc_channel_en = q.adc;
  assign o_pin_in         = q.filt;
  assign o_int_flag       = q.flag;
  assign o_irq            = q.irq;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  localparam int P0 = 0;
  // Input, filter and interrupt checks watch a pin with real traffic
  localparam int PI = 3;

  sequence held_high_raw;
    (!i_filter_en[PI] && i_pad_in[PI]) [*4];
  endsequence

  sequence rise_armed;
    $rose(o_pin_in[PI]) && i_int_edge_mode[PI] &&
      i_int_trigger[PI][iopc_pkg::TRIG_RISE_BIT];
  endsequence

  hiz_mode_a: assert property (
    i_out_mode[P0] == iopc_pkg::MODE_HIZ |=> !o_pad_oe[P0])
    else $error("pad driven in high-impedance mode");

  open_drain_a: assert property (
    i_out_mode[P0] == iopc_pkg::MODE_OPEN_DRAIN && !i_analog_en[P0]
    |=> !o_pad_out[P0])
    else $error("open-drain pin drove high");

  pull_follow_a: assert property (
    !i_analog_en[P0] |=> o_pull_up[P0] == $past(i_pull_up_en[P0]) &&
                         o_pull_down[P0] == $past(i_pull_down_en[P0]))
    else $error("pull enables not followed");

  drive_follow_a: assert property (
    1'b1 |=> o_drive_strength[P0] == $past(i_drive_strength[P0]))
    else $error("drive strength not followed");

  filter_bypass_a: assert property (
    held_high_raw |-> o_pin_in[PI])
    else $error("unfiltered input not seen after sync");

  filter_wait_a: assert property (
    i_filter_en[PI] && $past(i_filter_en[PI]) && $changed(o_pin_in[PI])
    |-> $past(q.cnt[PI]) == CNT_LAST)
    else $error("filtered input changed before count ran out");

  edge_flag_a: assert property (
    rise_armed |=> o_int_flag[PI])
    else $error("rising edge did not set flag");

  irq_gate_a: assert property (
    (o_int_flag & i_int_en) == '0 ##1 (o_int_flag & i_int_en) == '0
    |=> !o_irq)
    else $error("interrupt raised with no enabled flag");

  clear_set_a: assert property (
    o_int_flag[PI] && i_int_clear[PI] && !event_w[PI] |=> !o_int_flag[PI])
    else $error("flag not cleared");

  set_wins_a: assert property (
    event_w[PI] && i_int_clear[PI] |=> o_int_flag[PI])
    else $error("event lost during clear");

  analog_route_a: assert property (
    i_analog_en[iopc_pkg::PORT_D_BASE] |=>
      !o_pad_oe[iopc_pkg::PORT_D_BASE] && o_adc_channel_en[4])
    else $error("analog pin not routed to its channel");

  timer_b_a: assert property (
    i_pin_function_selector[P0] == iopc_pkg::SEL_TIMER_B &&
    i_out_mode[P0] == iopc_pkg::MODE_PUSH_PULL && !i_analog_en[P0]
    |=> o_pad_oe[P0] && o_pad_out[P0] == $past(i_timer_b_pwm_output[0]))
    else $error("timer B PWM not on pin");

  debug_tdo_a: assert property (
    i_pin_function_selector[iopc_pkg::DBG_TDO_PIN] == iopc_pkg::SEL_DEBUG &&
    i_out_mode[iopc_pkg::DBG_TDO_PIN] == iopc_pkg::MODE_PUSH_PULL
    |=> o_pad_out[iopc_pkg::DBG_TDO_PIN] == $past(i_debug_tdo_out))
    else $error("debug data out not on pin");

  reset_quiet_a: assert property (disable iff (1'b0)
    !i_rst_n |=> o_pad_oe == '0 && o_pull_up == '0 && !o_irq)
    else $error("pins not quiet after reset");

endmodule : iopc_pin_ctrl

// file: design/iopc_pkg.sv
package iopc_pkg;

  localparam int NUM_PINS = 31;
  localparam int NUM_SEL  = 8;
  localparam int NUM_ADC  = 8;

  // First pin index of each port, and the last pin index of port D
  localparam int PORT_C_BASE = 0;
  localparam int PORT_D_BASE = 8;
  localparam int PORT_E_BASE = 15;
  localparam int PORT_F_BASE = 19;
  localparam int PORT_G_BASE = 27;
  localparam int PORT_D_LAST = 14;

  // Debug port pins on port F
  localparam int DBG_CLK_PIN = PORT_F_BASE + 0;
  localparam int DBG_TMS_PIN = PORT_F_BASE + 1;
  localparam int DBG_TDI_PIN = PORT_F_BASE + 2;
  localparam int DBG_TDO_PIN = PORT_F_BASE + 3;

  localparam logic [2:0] SEL_GPIO    = 3'h0;
  localparam logic [2:0] SEL_TIMER_B = 3'h1;
  localparam logic [2:0] SEL_TIMER_C = 3'h2;
  localparam logic [2:0] SEL_DEBUG   = 3'h3;

  localparam logic [1:0] MODE_HIZ        = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL  = 2'h1;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h2;

  // Trigger bits: edge mode rise/fall, level mode high/low
  localparam int TRIG_RISE_BIT = 0;
  localparam int TRIG_FALL_BIT = 1;

  localparam int CLK_PERIOD_NS   = 5;
  localparam int DEBOUNCE_NS     = 100;
  localparam int DEBOUNCE_CYCLES =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ADC channel of each pin, zero where the pin has no analog input
  function automatic logic [2:0] adc_channel(input int p);
    if (p == PORT_D_BASE + 0) return 3'h4;
    else if (p == PORT_D_BASE + 1) return 3'h3;
    else if (p == PORT_D_BASE + 2) return 3'h2;
    else if (p == PORT_D_BASE + 3) return 3'h1;
    else if (p >= PORT_F_BASE + 4 && p <= PORT_F_BASE + 7)
      return 3'(p - PORT_F_BASE);
    else return 3'h0;
  endfunction : adc_channel

endpackage : iopc_pkg

// file: testbench/iopc_pad_model.sv
`timescale 1ns/1ps
module iopc_pad_model (
  // Clock
  input  wire logic                          i_clk,
  // Device pad drive
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_pad_out,
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_pad_oe,
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_pull_up,
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_pull_down,
  // External drivers
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_ext_en,
  input  wire logic [iopc_pkg::NUM_PINS-1:0] i_ext_val,
  // Resolved pin level
  output logic      [iopc_pkg::NUM_PINS-1:0] o_level
);
  logic [iopc_pkg::NUM_PINS-1:0] float_q = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Undriven pin wanders every cycle rather than holding a value
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int p = 0; p < iopc_pkg::NUM_PINS; p++) begin
      if (i_pad_oe[p]) o_level[p] = i_pad_out[p];
      else if (i_ext_en[p]) o_level[p] = i_ext_val[p];
      else if (i_pull_up[p]) o_level[p] = 1'b1;
      else if (i_pull_down[p]) o_level[p] = 1'b0;
      else o_level[p] = float_q[p];
    end
  end
endmodule : iopc_pad_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int NP = iopc_pkg::NUM_PINS;
  localparam int DB = 4;
  logic clk, i_rst_n, i_debug_swdio_out, i_debug_swdio_oe, i_debug_tdo_out;
  logic [NP-1:0][1:0] i_out_mode, i_int_trigger;
  logic [NP-1:0][2:0] i_drive_strength, i_pin_function_selector;
  logic [NP-1:0][7:0] i_func_out, i_func_oe;
  logic [NP-1:0]      i_pull_up_en, i_pull_down_en, i_filter_en, i_analog_en;
  logic [NP-1:0]      i_int_edge_mode, i_int_en, i_int_clear, i_gpio_out;
  logic [NP-1:0]      i_pad_in, ext_en, ext_val, r;
  logic [7:0]         i_timer_b_pwm_output, i_timer_c_pwm_output;
  logic [NP-1:0]      o_pad_out, o_pad_oe, o_pull_up, o_pull_down;
  logic [NP-1:0]      o_analog_route, o_pin_in, o_int_flag;
  logic [NP-1:0][2:0] o_drive_strength;
  logic [7:0]         o_adc_channel_en;
  logic               o_irq, e;
  int                 n_mismatch, check_count;
  integer             seed;
  ////////////////////////////////////////////////////////////////////////////
  iopc_pin_ctrl #(.DEBOUNCE_CYCLES(DB)) u_iopc_pin_ctrl (
    .i_clk(clk), .i_rst_n(i_rst_n), .i_out_mode(i_out_mode),
    .i_pull_up_en(i_pull_up_en), .i_pull_down_en(i_pull_down_en),
    .i_drive_strength(i_drive_strength), .i_filter_en(i_filter_en),
    .i_analog_en(i_analog_en),
    .i_pin_function_selector(i_pin_function_selector),
    .i_int_edge_mode(i_int_edge_mode), .i_int_trigger(i_int_trigger),
    .i_int_en(i_int_en), .i_int_clear(i_int_clear),
    .i_gpio_out(i_gpio_out), .i_func_out(i_func_out), .i_func_oe(i_func_oe),
    .i_timer_b_pwm_output(i_timer_b_pwm_output),
    .i_timer_c_pwm_output(i_timer_c_pwm_output),
    .i_debug_swdio_out(i_debug_swdio_out),
    .i_debug_swdio_oe(i_debug_swdio_oe), .i_debug_tdo_out(i_debug_tdo_out),
    .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_pull_up(o_pull_up), .o_pull_down(o_pull_down),
    .o_drive_strength(o_drive_strength), .o_analog_route(o_analog_route),
    .o_adc_channel_en(o_adc_channel_en), .o_pin_in(o_pin_in),
    .o_int_flag(o_int_flag), .o_irq(o_irq));
  iopc_pad_model u_iopc_pad_model (
    .i_clk(clk), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
    .i_pull_up(o_pull_up), .i_pull_down(o_pull_down), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(i_pad_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_vec
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic clr3();
    i_int_clear[3] = 1'b1;
    tick(1);
    i_int_clear[3] = 1'b0;
    tick(1);
  endtask : clr3
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hd2ec;
    {i_pull_up_en, i_pull_down_en, i_filter_en, i_analog_en} = '0;
    {i_pin_function_selector, i_drive_strength, i_func_out, i_func_oe} = '0;
    {i_int_edge_mode, i_int_trigger, i_int_en, i_int_clear, ext_en} = '0;
    {i_timer_b_pwm_output, i_timer_c_pwm_output, ext_val} = '0;
    {i_debug_swdio_out, i_debug_swdio_oe, i_debug_tdo_out} = '0;
    i_out_mode = {NP{2'h1}};
    i_gpio_out = '1;
    i_rst_n = 1'b0;
    tick(16);
    chk_vec(32'(o_pad_oe), 32'h0, "reset oe");
    chk_vec(32'(o_int_flag | o_pull_up), 32'h0, "reset quiet");
    i_rst_n = 1'b1;
    for (int m = 0; m < 8; m++) begin
      i_out_mode = {NP{m[2:1]}};
      i_gpio_out = NP'($random(seed));
      tick(1);
      for (int p = 0; p < NP; p++) begin
        e = (m[2:1] == 2'h1) ? 1'b1 : (m[2:1] == 2'h2) ? ~i_gpio_out[p] : 1'b0;
        chk_bit(o_pad_oe[p], e, "mode oe");
        e = m[2:1] == 2'h1 && i_gpio_out[p];
        chk_bit(o_pad_out[p], e, "mode out");
      end
    end
    $display("test modes done");
    for (int k = 0; k < 4; k++) begin
      r = NP'($random(seed));
      i_pull_up_en = r;
      i_pull_down_en = ~r & NP'($random(seed));  // Never both at once
      for (int p = 0; p < NP; p++) i_drive_strength[p] = 3'($random(seed));
      tick(1);
      chk_vec(32'(o_pull_up), 32'(i_pull_up_en), "pull up");
      chk_vec(32'(o_pull_down), 32'(i_pull_down_en), "pull down");
      for (int p = 0; p < NP; p++)
        chk_vec(32'(o_drive_strength[p]), 32'(i_drive_strength[p]),
                "ds");
    end
    $display("test pulls done");
    i_out_mode = {NP{2'h1}};
    {i_pull_up_en, i_pull_down_en} = '0;
    for (int s = 1; s < 3; s++) begin
      i_timer_b_pwm_output = 8'($random(seed));
      i_timer_c_pwm_output = 8'($random(seed));
      i_pin_function_selector = {NP{s[2:0]}};
      tick(1);
      for (int p = 0; p <= iopc_pkg::PORT_D_LAST; p++) begin
        e = (s == 1) ? i_timer_b_pwm_output[p % 8]
                     : i_timer_c_pwm_output[p % 8];
        chk_bit(o_pad_out[p], e, "pwm out");
        chk_bit(o_pad_oe[p], 1'b1, "pwm oe");
      end
    end
    for (int s = 4; s < 8; s++) begin
      i_pin_function_selector[27] = 3'(s);
      i_func_out[27] = 8'($random(seed));
      i_func_oe[27] = 8'($random(seed));
      tick(1);
      chk_bit(o_pad_out[27], i_func_out[27][s], "func out");
      chk_bit(o_pad_oe[27], i_func_oe[27][s], "func oe");
    end
    for (int p = 19; p < 23; p++) i_pin_function_selector[p] = 3'h3;
    {i_debug_swdio_out, i_debug_swdio_oe, i_debug_tdo_out} =
      3'($random(seed));
    tick(1);
    chk_bit(o_pad_oe[19], 1'b0, "dbg clk oe");
    chk_bit(o_pad_oe[21], 1'b0, "dbg tdi oe");
    chk_bit(o_pad_oe[22], 1'b1, "tdo oe");
    chk_bit(o_pad_oe[20], i_debug_swdio_oe, "swdio oe");
    chk_bit(o_pad_out[20], i_debug_swdio_out, "swdio out");
    chk_bit(o_pad_out[22], i_debug_tdo_out, "tdo out");
    $display("test mux done");
    i_pin_function_selector = '0;
    i_gpio_out = '1;
    i_pull_up_en[8] = 1'b1;
    i_analog_en = NP'(32'h0400_0901);
    tick(1);
    chk_vec(32'(o_analog_route), 32'h0400_0900, "route");
    chk_vec(32'(o_adc_channel_en), 32'h92, "adc en");
    chk_bit(o_pad_oe[8] | o_pull_up[8], 1'b0, "analog quiet");
    chk_bit(o_pad_oe[0], 1'b1, "no channel");
    i_analog_en = '1;
    tick(1);
    chk_vec(32'(o_analog_route), 32'h0780_0f00, "all routes");
    chk_vec(32'(o_adc_channel_en), 32'hfe, "all channels");
    $display("test analog done");
    {i_analog_en, i_pull_up_en, i_out_mode} = '0;
    ext_en[3] = 1'b1;
    tick(8);
    {i_int_edge_mode[3], i_int_en[3]} = 2'b11;
    for (int t = 1; t < 4; t++) begin
      i_int_trigger[3] = 2'(t);
      ext_val[3] = 1'b1;
      tick(8);
      chk_bit(o_pin_in[3], 1'b1, "pin in");
      chk_bit(o_int_flag[3], t[0], "rise flag");
      chk_bit(o_irq, t[0], "rise irq");
      clr3();
      chk_bit(o_int_flag[3], 1'b0, "cleared");
      ext_val[3] = 1'b0;
      tick(8);
      chk_bit(o_int_flag[3], t[1], "fall flag");
      clr3();
    end
    i_int_en[3] = 1'b0;
    i_int_edge_mode[3] = 1'b0;
    i_int_trigger[3] = 2'b10;
    tick(4);
    chk_bit(o_int_flag[3], 1'b1, "level flag");
    chk_bit(o_irq, 1'b0, "masked irq");
    clr3();
    chk_bit(o_int_flag[3], 1'b1, "set wins");
    i_int_trigger[3] = 2'b01;
    clr3();
    tick(4);
    chk_bit(o_int_flag[3], 1'b0, "level idle");
    $display("test interrupts done");
    i_filter_en[3] = 1'b1;
    i_int_trigger[3] = 2'b00;
    tick(8);
    ext_val[3] = 1'b1;
    tick(DB - 1);
    ext_val[3] = 1'b0;
    tick(12);
    chk_bit(o_pin_in[3], 1'b0, "glitch rejected");
    ext_val[3] = 1'b1;
    tick(DB + 1);
    chk_bit(o_pin_in[3], 1'b0, "filter counting");
    tick(1);
    chk_bit(o_pin_in[3], 1'b1, "filtered level");
    $display("test filter done");
    complete_run();
  end
endmodule : tb
